// [hdl/dcil_change_irq.sv]
// module: input change interrupt controller top with apb register slave
//
// Contract
// - eight sources, one per input channel
// - per-source enable bit gates requests
// - polarity zero inverts input, one passes
// - single level request output, active low
// - low pulse once, held low repeats
// - equal priority sources merge to one request
// - software reads all source levels together
// - polarity at 0x2a, inputs at 7
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcil_change_irq #(
	parameter int unsigned CHANNELS = dcil_pkg::CHANNELS
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [CHANNELS-1:0]       inputPosLeg,
	input  wire logic [CHANNELS-1:0]       inputNegLeg,
	input  wire dcil_pkg::dcil_apb_req_type apbReq,
	output var  dcil_pkg::dcil_apb_rsp_type apbRsp,
	output var  logic                      interruptRequest_n,
	output var  logic                      eventIrq
);
	typedef struct packed {
		logic [7:0]       polarity;
		logic [7:0]       mask;
		logic [7:0]       evtStatus;
		logic [7:0]       evtMask;
		logic [7:0]       prevSource;
		logic             irqN;
		logic             evtIrq;
		dcil_pkg::dcil_apb_rsp_type rsp;
	} dcil_top_state_type;

	dcil_top_state_type st;
	dcil_top_state_type next_st;
	logic [CHANNELS-1:0] diffLevel;
	logic [CHANNELS-1:0] inputLevel;
	logic [CHANNELS-1:0] source;
	logic [CHANNELS-1:0] gated;
	logic [CHANNELS-1:0] rise;
	logic                access;
	logic                hit;
	logic [31:0]         rdata;

	initial begin
		if (CHANNELS != 8) $error("register layout serves exactly eight channels");
	end

	// differential pair: channel reads high when the positive leg leads
	assign diffLevel = inputPosLeg & ~inputNegLeg;

	dcil_in_sync #(
		.WIDTH (CHANNELS)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.async (diffLevel),
		.level (inputLevel)
	);

	dcil_source_gate #(
		.WIDTH (CHANNELS)
	) u_gate (
		.inputLevel (inputLevel),
		.polarity   (st.polarity),
		.enable     (st.mask),
		.source     (source),
		.gated      (gated)
	);

	// new source pulses raise sticky change events
	assign rise = gated & ~st.prevSource;
	assign access = apbReq.psel & apbReq.penable;

	function automatic logic [9:0] word_addr(input logic [11:0] a);
		return a[11:2];
	endfunction

	// read mux; unmapped words read zero and flag an error
	always_comb begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		unique case (word_addr(apbReq.paddr))
			dcil_pkg::ADDR_INPUT_STATE[9:0] >> 2: rdata = {24'h00_0000, inputLevel};
			dcil_pkg::ADDR_POLARITY >> 2: rdata = {24'h00_0000, st.polarity};
			dcil_pkg::ADDR_MASK >> 2: rdata = {24'h00_0000, st.mask};
			dcil_pkg::ADDR_EVT_STATUS >> 2: rdata = {24'h00_0000, st.evtStatus};
			dcil_pkg::ADDR_EVT_MASK >> 2: rdata = {24'h00_0000, st.evtMask};
			default: hit = 1'b0;
		endcase
	end

	// register file, event status and request output
	always_comb begin
		next_st = st;
		next_st.rsp.pready = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		next_st.prevSource = gated;
		if (access && !st.rsp.pready) begin
			next_st.rsp.pready = 1'b1;
			next_st.rsp.pslverr = ~hit;
			next_st.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdata;
			if (apbReq.pwrite) begin
				unique case (word_addr(apbReq.paddr))
					dcil_pkg::ADDR_POLARITY >> 2: next_st.polarity = apbReq.pwdata[7:0];
					dcil_pkg::ADDR_MASK >> 2: next_st.mask = apbReq.pwdata[7:0];
					dcil_pkg::ADDR_EVT_MASK >> 2: next_st.evtMask = apbReq.pwdata[7:0];
					default: ;
				endcase
			end else if (word_addr(apbReq.paddr) == (dcil_pkg::ADDR_EVT_STATUS >> 2)) begin
				next_st.evtStatus = 8'h00; // read clears
			end
		end
		// set wins over the clear of the same cycle
		next_st.evtStatus = next_st.evtStatus | rise;
		// any enabled source drives the shared line: no priority, one request
		next_st.irqN = ~(|gated);
		next_st.evtIrq = |(next_st.evtStatus & st.evtMask);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.polarity <= dcil_pkg::RST_POLARITY;
			st.mask <= dcil_pkg::RST_MASK;
			st.evtMask <= dcil_pkg::RST_EVT_MASK;
			st.irqN <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign apbRsp = st.rsp;
	assign interruptRequest_n = st.irqN;
	assign eventIrq = st.evtIrq;

	// request follows enabled sources one cycle later
	chk_request_level: assert property (@(posedge clk) disable iff (!rst_n)
		(|gated) |=> !interruptRequest_n) else $error("request not asserted");
	chk_request_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!(|gated) |=> interruptRequest_n) else $error("request not released");
	chk_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
		(st.mask == 8'h00) |=> interruptRequest_n) else $error("masked source requested");
	chk_polarity_invert: assert property (@(posedge clk) disable iff (!rst_n)
		(st.polarity[0] == 1'b0) |-> (source[0] == !inputLevel[0]))
		else $error("polarity zero not inverting");
	chk_merge_once: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(&gated) && $past(gated) == 8'h00 |=> $fell(interruptRequest_n))
		else $error("merged request wrong");
	chk_held_low: assert property (@(posedge clk) disable iff (!rst_n)
		(|gated)[*3] |=> !interruptRequest_n) else $error("held request dropped");
	chk_input_read: assert property (@(posedge clk) disable iff (!rst_n)
		access && !apbReq.pwrite && !st.rsp.pready
		&& apbReq.paddr[11:2] == (dcil_pkg::ADDR_INPUT_STATE >> 2)
		|=> apbRsp.pready && apbRsp.prdata[7:0] == $past(inputLevel))
		else $error("input state read wrong");
	chk_pol_write: assert property (@(posedge clk) disable iff (!rst_n)
		access && apbReq.pwrite && !st.rsp.pready
		&& apbReq.paddr[11:2] == (dcil_pkg::ADDR_POLARITY >> 2)
		|=> st.polarity == $past(apbReq.pwdata[7:0])) else $error("polarity write lost");
	chk_sticky_event: assert property (@(posedge clk) disable iff (!rst_n)
		rise[0] |=> st.evtStatus[0]) else $error("event not captured");
	cov_request: cover property (@(posedge clk) disable iff (!rst_n) $fell(interruptRequest_n));
	cov_all_sources: cover property (@(posedge clk) disable iff (!rst_n) &gated);
	cov_event_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(eventIrq));
endmodule
`default_nettype wire

// [hdl/dcil_in_sync.sv]
// module: three-stage synchroniser with agreement filter for the input legs
`timescale 1ns/1ps
`default_nettype none
module dcil_in_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async,
	output var  logic [WIDTH-1:0] level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} dcil_sync_state_type;

	dcil_sync_state_type st;
	dcil_sync_state_type next_st;

	initial begin
		if (WIDTH < 1) $error("width must be positive");
	end

	// level moves only when stage two and three agree
	always_comb begin
		next_st = st;
		next_st.s1 = async;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) next_st.lvl[i] = st.s3[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) st <= '0;
		else st <= next_st;
	end

	assign level = st.lvl;
endmodule
`default_nettype wire

// [hdl/dcil_pkg.sv]
// package: register map, reset values and carrier types of the input change interrupt block
package dcil_pkg;
	localparam int unsigned CHANNELS = 8;
	// register byte addresses (printed offsets 0x7 and 0x2a are indices)
	localparam logic [7:0] IDX_INPUT_STATE = 8'h07;
	localparam logic [7:0] IDX_POLARITY = 8'h2a;
	localparam logic [7:0] IDX_MASK = 8'h2b;
	localparam logic [7:0] IDX_EVT_STATUS = 8'h2c;
	localparam logic [7:0] IDX_EVT_MASK = 8'h2d;
	localparam logic [9:0] ADDR_INPUT_STATE = {IDX_INPUT_STATE, 2'b00};
	localparam logic [9:0] ADDR_POLARITY = {IDX_POLARITY, 2'b00};
	localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
	localparam logic [9:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
	localparam logic [9:0] ADDR_EVT_MASK = {IDX_EVT_MASK, 2'b00};
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_EVT_MASK = 8'h00;
	localparam int unsigned SYNC_STAGES = 3;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dcil_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dcil_apb_rsp_type;
endpackage

// [hdl/dcil_source_gate.sv]
// module: per-channel polarity select and enable gate forming the interrupt sources
`timescale 1ns/1ps
`default_nettype none
module dcil_source_gate #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] inputLevel,
	input  wire logic [WIDTH-1:0] polarity,
	input  wire logic [WIDTH-1:0] enable,
	output var  logic [WIDTH-1:0] source,
	output var  logic [WIDTH-1:0] gated
);
	// one gate per channel
	for (genvar g = 0; g < WIDTH; g++) begin : gen_ch
		assign source[g] = polarity[g] ? inputLevel[g] : ~inputLevel[g];
		assign gated[g] = source[g] & enable[g];
	end
endmodule
`default_nettype wire

// [testbench/dcil_host_model.sv]
// host side model: counts interrupts taken from the request line
`timescale 1ns/1ps
`default_nettype none
module dcil_host_model (
	input  wire logic clk,
	input  wire logic irqReq_n,
	output var  int   taken
);
	logic prev = 1'b1;
	int   count = 0;
	// one falling edge is one interrupt; a held level is not counted twice here
	always @(posedge clk) begin
		if (prev === 1'b1 && irqReq_n === 1'b0) count <= count + 1;
		prev <= irqReq_n;
	end
	assign taken = count;
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// testbench: apb host, input stimulus and checks for the change interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst_n, irqN, evtIrq, er;
	logic [7:0] pos, neg, pol, msk, lvl;
	logic [31:0] rd;
	logic [15:0] s;
	dcil_pkg::dcil_apb_req_type req;
	dcil_pkg::dcil_apb_rsp_type rsp;
	int failures = 0, check_count = 0, cyc = 0, taken, n;
	localparam logic [11:0] A_IN = {2'h0, dcil_pkg::ADDR_INPUT_STATE};
	localparam logic [11:0] A_POL = {2'h0, dcil_pkg::ADDR_POLARITY};
	localparam logic [11:0] A_MSK = {2'h0, dcil_pkg::ADDR_MASK};
	localparam logic [11:0] A_EVS = {2'h0, dcil_pkg::ADDR_EVT_STATUS};
	localparam logic [11:0] A_EVM = {2'h0, dcil_pkg::ADDR_EVT_MASK};
	dcil_change_irq i_dut (.clk(clk), .rst_n(rst_n), .inputPosLeg(pos), .inputNegLeg(neg),
		.apbReq(req), .apbRsp(rsp), .interruptRequest_n(irqN), .eventIrq(evtIrq));
	dcil_host_model i_host (.clk(clk), .irqReq_n(irqN), .taken(taken));
	// 125 mhz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard, well above the ~550 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// request is low while any enabled, polarity-selected source is high
	function automatic logic [31:0] expIrq(input logic [7:0] l, p, m);
		return {31'h0, ~|(m & ~(p ^ l))};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= {24'h0, d};
		@(posedge clk);
		req.penable <= 1'b1;
		// pready is judged at the rising edge, with the request still standing
		do begin
			@(posedge clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		if (k >= 50) failures++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	// let a pin change cross the synchroniser; the host sees it held
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	task automatic conclude();
		$display("counts: %0d checks, %0d mismatches", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		pos = 8'h00;
		neg = 8'h00;
		req = '0;
		s = 16'h0017;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({31'h0, irqN}, 32'h1);
		apb(0, A_POL, 8'h00); chk(rd, 32'h0);
		apb(0, A_MSK, 8'h00); chk(rd, 32'h0);
		apb(1, A_IN, 8'h5a); apb(0, A_IN, 8'h00); chk(rd, 32'h0);
		apb(0, 12'h000, 8'h00); chk({er, rd[30:0]}, 32'h80000000);
		$display("test reset done");
		// all eight sources rise together: one request only
		apb(1, A_POL, 8'hff); apb(1, A_MSK, 8'hff);
		n = taken;
		pos <= 8'hff;
		settle();
		@(negedge clk);
		chk({31'h0, irqN}, 32'h0);
		chk(32'(taken), 32'(n + 1));
		// host flips polarity so the sources rest low again
		@(posedge clk);
		apb(1, A_POL, 8'h00);
		@(negedge clk);
		chk({31'h0, irqN}, 32'h1);
		@(posedge clk);
		apb(0, A_IN, 8'h00); chk(rd, 32'hff);
		$display("test merge done");
		// sticky events: ch0 unmasked, ch1 masked in event mask
		apb(1, A_EVM, 8'h01); apb(0, A_EVS, 8'h00);
		pos <= 8'hfc;
		settle();
		@(negedge clk);
		chk({31'h0, evtIrq}, 32'h1);
		@(posedge clk);
		apb(0, A_EVS, 8'h00); chk(rd, 32'h3);
		chk({31'h0, evtIrq}, 32'h0);
		apb(0, A_EVS, 8'h00); chk(rd, 32'h0);
		$display("test event done");
		// two inputs change at once; handler compares and flips both in one polarity write
		apb(1, A_POL, 8'h03);
		lvl = 8'hfc;
		@(negedge clk);
		chk({31'h0, irqN}, 32'h1);
		@(posedge clk);
		pos <= 8'hf9;
		settle();
		@(negedge clk);
		chk({31'h0, irqN}, 32'h0);
		@(posedge clk);
		apb(0, A_IN, 8'h00); chk(rd, 32'hf9);
		pol = 8'h03;
		for (int c = 0; c < 8; c++) begin
			if (rd[c] != lvl[c]) pol[c] = ~pol[c];
		end
		lvl = rd[7:0];
		apb(1, A_POL, pol);
		@(negedge clk);
		chk({31'h0, irqN}, 32'h1);
		@(posedge clk);
		$display("test multi done");
		// random polarity, enables and pin pairs
		for (int i = 0; i < 24; i++) begin
			s = lfsr(s); pol = s[7:0]; msk = s[15:8];
			s = lfsr(s); lvl = s[7:0] & ~s[15:8];
			apb(1, A_POL, pol); apb(1, A_MSK, msk);
			pos <= s[7:0];
			neg <= s[15:8];
			settle();
			apb(0, A_IN, 8'h00); chk(rd, {24'h0, lvl});
			@(negedge clk);
			chk({31'h0, irqN}, expIrq(lvl, pol, msk));
			@(posedge clk);
		end
		$display("test random done");
		conclude();
	end
endmodule
`default_nettype wire
